// File: rtcui_pkg.sv
// Shared constants, types and state layouts for the update/clock-output block
package rtcui_pkg;
   // ************************************************************
   // Register offsets and fields
   // ************************************************************
   localparam logic [7:0] REG_EXT = 8'h1d;
   localparam logic [7:0] REG_FLAGS = 8'h1e;
   localparam logic [7:0] REG_CTRL = 8'h1f;
   localparam logic [7:0] REG_ROUTE = 8'h32;
   localparam int EXT_PERIOD_BIT = 5;
   localparam int EXT_FREQ_LO_BIT = 6;
   localparam int EXT_FREQ_HI_BIT = 7;
   localparam int FLG_UPDATE_BIT = 5;
   localparam int FLG_LOSS_BIT = 1;
   localparam int CTL_UPD_IE_BIT = 5;
   localparam int CTL_HALT_BIT = 6;
   localparam int ROUTE_W = 3;
   localparam logic [7:0] EXT_RST = 8'h00;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [2:0] ROUTE_RST = 3'h0;
   localparam logic LOSS_RST = 1'b1;
   // Frequency and pin codes
   localparam logic [1:0] FREQ_OFF = 2'h0;
   localparam logic [1:0] FREQ_1HZ = 2'h1;
   localparam logic [1:0] FREQ_1K = 2'h2;
   localparam logic [1:0] FREQ_32K = 2'h3;
   localparam logic [1:0] PIN_B = 2'h0;
   localparam logic [1:0] PIN_A = 2'h1;
   // ************************************************************
   // Divider chain and timing
   // ************************************************************
   localparam int DIV_W = 15;
   localparam int DIV_1K_BIT = 4;
   localparam int DIV_1HZ_BIT = 14;
   localparam logic [14:0] DIV_WRAP = 15'h7fff;
   localparam logic [5:0] SEC_LAST = 6'h3b;
   localparam int SYS_CLK_HZ = 20000000;
   localparam int SYS_PERIOD_NS = 1000000000 / SYS_CLK_HZ;
   localparam int IRQ_HOLD_NS = 7813000;
   localparam int IRQ_HOLD_CYC = IRQ_HOLD_NS / SYS_PERIOD_NS;
   localparam int HOLD_W = 18;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   // Serial slave address, value arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h32;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_AACK = 7'h04,
      ST_WR = 7'h08,
      ST_WACK = 7'h10,
      ST_RD = 7'h20,
      ST_RACK = 7'h40
   } rtcui_st_t;
   typedef struct packed {
      logic hz1k;
      logic hz1;
      logic sec_t;
      logic min_t;
   } rtcui_tick_t;
   typedef struct packed {
      logic scl;
      logic sda;
      logic loss;
      logic backup;
      logic osc;
      rtcui_tick_t tick;
   } rtcui_async_t;
   typedef struct packed {
      logic halt_m;
      logic halt_s;
      logic [14:0] div;
      logic [5:0] sec;
      logic sec_t;
      logic min_t;
   } rtcui_osc_t;
   typedef struct packed {
      rtcui_st_t st;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic rw;
      logic got_ptr;
      logic mnack;
      logic sda_drv;
      logic scl_q;
      logic sda_q;
      logic sec_q;
      logic min_q;
      logic [7:0] ext;
      logic [7:0] ctl;
      logic [2:0] route;
      logic update_event_flag;
      logic data_loss_flag;
      logic irq_act;
      logic [17:0] hold;
      logic pin_lo;
      logic sda_oe_n;
      logic irqa_oe_n;
      logic irqb_oe_n;
   } rtcui_state_t;
endpackage

// File: rtcui_sync.sv
// Two-flop level synchroniser for a vector of unrelated inputs
`timescale 1ns/1ps
module rtcui_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] m;
      logic [W-1:0] s;
   } rtcui_sync_st_t;
   rtcui_sync_st_t s_r, s_nxt;

   // First stage feeds only the second
   always_comb begin
      s_nxt = s_r;
      s_nxt.m = d_i;
      s_nxt.s = s_r.m;
   end

   // Register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.s;
endmodule

// File: rtcui_osc_div.sv
// Oscillator-domain divider chain with second and minute tick toggles
`timescale 1ns/1ps
module rtcui_osc_div (
   // Oscillator clock and reset
   input wire logic osc_clk_i,
   input wire logic rstn_i,
   // Halt level from system domain
   input wire logic halt_i,
   // Tick levels and toggles
   output rtcui_pkg::rtcui_tick_t tick_o
);
   rtcui_pkg::rtcui_osc_t s_r, s_nxt;

   // ************************************************************
   // Divider
   // ************************************************************
   // Halt clears the sub-second chain so no tick or slow clock leaks out
   always_comb begin
      s_nxt = s_r;
      s_nxt.halt_m = halt_i;
      s_nxt.halt_s = s_r.halt_m;
      if (s_r.halt_s) begin
         s_nxt.div = '0;
      end else begin
         s_nxt.div = s_r.div + 15'h0001;
         if (s_r.div == rtcui_pkg::DIV_WRAP) begin
            s_nxt.sec_t = ~s_r.sec_t;
            if (s_r.sec == rtcui_pkg::SEC_LAST) begin
               s_nxt.sec = '0;
               s_nxt.min_t = ~s_r.min_t;
            end else begin
               s_nxt.sec = s_r.sec + 6'h01;
            end
         end
      end
   end

   // Register
   always_ff @(posedge osc_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_o.hz1k = s_r.div[rtcui_pkg::DIV_1K_BIT];
   assign tick_o.hz1 = s_r.div[rtcui_pkg::DIV_1HZ_BIT];
   assign tick_o.sec_t = s_r.sec_t;
   assign tick_o.min_t = s_r.min_t;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking osc_cb @(posedge osc_clk_i);
   endclocking
   default disable iff (!rstn_i);

   chk_halt_no_tick: assert property (s_r.halt_s |=> $stable(s_r.sec_t) && s_r.div == '0)
      else $error("second tick toggled while halted");
   chk_minute_rollover: assert property ($changed(s_r.min_t) |-> $changed(s_r.sec_t) && s_r.sec == '0)
      else $error("minute tick without second rollover");
endmodule

// File: rtcui_top.sv
// Update events, data-loss flag, clock output routing and serial register access
`timescale 1ns/1ps
module rtcui_top #(
   parameter int IRQ_HOLD_CYC = rtcui_pkg::IRQ_HOLD_CYC,
   parameter logic [6:0] DEV_ADDR = rtcui_pkg::DEV_ADDR_DEF
) (
   // Clocks and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic osc_clk_i,
   // Serial register bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Open-drain interrupt and clock pins
   output logic interrupt_out_a_o,
   output logic interrupt_out_a_oe_n_o,
   output logic interrupt_out_b_o,
   output logic interrupt_out_b_oe_n_o,
   // Supply monitor
   input wire logic data_loss_i,
   input wire logic backup_i
);
   localparam logic [17:0] HOLD_LD = 18'(IRQ_HOLD_CYC);

   rtcui_pkg::rtcui_state_t s_r, s_nxt;
   rtcui_pkg::rtcui_tick_t tick;
   rtcui_pkg::rtcui_async_t raw, sy;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic upd_evt, wr_en, upd_clr, loss_clr;
   logic [1:0] freq_sel, pin_sel;
   logic halt, ck_lvl;

   // ************************************************************
   // Oscillator domain and crossings
   // ************************************************************
   rtcui_osc_div u_osc (
      .osc_clk_i(osc_clk_i),
      .rstn_i(rstn_i),
      .halt_i(s_r.ctl[rtcui_pkg::CTL_HALT_BIT]),
      .tick_o(tick)
   );

   // Pins and oscillator levels all pass two flops
   assign raw = '{scl: scl_i, sda: sda_i, loss: data_loss_i, backup: backup_i, osc: osc_clk_i, tick: tick};

   rtcui_sync #(.W($bits(rtcui_pkg::rtcui_async_t))) u_sync (
      .clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .d_i(raw),
      .q_o(sy)
   );

   // Bus edges and conditions from synchronised lines
   assign scl_rise = sy.scl & ~s_r.scl_q;
   assign scl_fall = ~sy.scl & s_r.scl_q;
   assign bus_start = sy.scl & s_r.scl_q & s_r.sda_q & ~sy.sda;
   assign bus_stop = sy.scl & s_r.scl_q & ~s_r.sda_q & sy.sda;

   // Update event from tick toggles; halt also masks a tick still in flight
   assign halt = s_r.ctl[rtcui_pkg::CTL_HALT_BIT];
   assign upd_evt = ~halt & (s_r.ext[rtcui_pkg::EXT_PERIOD_BIT] ? (sy.tick.min_t ^ s_r.min_q)
                                                               : (sy.tick.sec_t ^ s_r.sec_q));
   assign freq_sel = {s_r.ext[rtcui_pkg::EXT_FREQ_HI_BIT], s_r.ext[rtcui_pkg::EXT_FREQ_LO_BIT]};
   assign pin_sel = s_r.route[1:0];

   // Register read image; unmapped addresses read zero
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input rtcui_pkg::rtcui_state_t v);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         rtcui_pkg::REG_EXT: begin
            d = v.ext;
         end
         rtcui_pkg::REG_FLAGS: begin
            d[rtcui_pkg::FLG_UPDATE_BIT] = v.update_event_flag;
            d[rtcui_pkg::FLG_LOSS_BIT] = v.data_loss_flag;
         end
         rtcui_pkg::REG_CTRL: begin
            d = v.ctl;
         end
         rtcui_pkg::REG_ROUTE: begin
            d[rtcui_pkg::ROUTE_W-1:0] = v.route;
         end
         default: begin
            d = 8'h00;
         end
      endcase
      return d;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      wr_en = 1'b0;
      ck_lvl = 1'b1;
      s_nxt.scl_q = sy.scl;
      s_nxt.sda_q = sy.sda;
      s_nxt.sec_q = sy.tick.sec_t;
      s_nxt.min_q = sy.tick.min_t;
      // Serial slave; start wins over everything, even mid-byte
      if (bus_start) begin
         s_nxt.st = rtcui_pkg::ST_ADDR;
         s_nxt.bit_cnt = 4'h0;
         s_nxt.sda_drv = 1'b0;
         s_nxt.got_ptr = 1'b0;
      end else if (bus_stop) begin
         s_nxt.st = rtcui_pkg::ST_IDLE;
         s_nxt.sda_drv = 1'b0;
      end else begin
         case (s_r.st)
            rtcui_pkg::ST_IDLE: begin
               s_nxt.sda_drv = 1'b0;
            end
            rtcui_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  s_nxt.shreg = {s_r.shreg[6:0], sy.sda};
                  s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
               end else if (scl_fall && s_r.bit_cnt == rtcui_pkg::BITS_BYTE) begin
                  if (s_r.shreg[7:1] == DEV_ADDR) begin
                     s_nxt.sda_drv = 1'b1;
                     s_nxt.rw = s_r.shreg[0];
                     s_nxt.st = rtcui_pkg::ST_AACK;
                  end else begin
                     s_nxt.st = rtcui_pkg::ST_IDLE;
                  end
               end
            end
            rtcui_pkg::ST_AACK: begin
               if (scl_fall) begin
                  s_nxt.bit_cnt = 4'h0;
                  if (s_r.rw) begin
                     s_nxt.shreg = rd_byte(s_r.ptr, s_r);
                     s_nxt.sda_drv = ~s_nxt.shreg[7];
                     s_nxt.st = rtcui_pkg::ST_RD;
                  end else begin
                     s_nxt.sda_drv = 1'b0;
                     s_nxt.st = rtcui_pkg::ST_WR;
                  end
               end
            end
            rtcui_pkg::ST_WR: begin
               if (scl_rise) begin
                  s_nxt.shreg = {s_r.shreg[6:0], sy.sda};
                  s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
               end else if (scl_fall && s_r.bit_cnt == rtcui_pkg::BITS_BYTE) begin
                  s_nxt.sda_drv = 1'b1;
                  s_nxt.st = rtcui_pkg::ST_WACK;
                  // First byte is the pointer, later bytes auto-increment
                  if (!s_r.got_ptr) begin
                     s_nxt.ptr = s_r.shreg;
                     s_nxt.got_ptr = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                     s_nxt.ptr = s_r.ptr + 8'h01;
                  end
               end
            end
            rtcui_pkg::ST_WACK: begin
               if (scl_fall) begin
                  s_nxt.sda_drv = 1'b0;
                  s_nxt.bit_cnt = 4'h0;
                  s_nxt.st = rtcui_pkg::ST_WR;
               end
            end
            rtcui_pkg::ST_RD: begin
               if (scl_rise) begin
                  s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (s_r.bit_cnt == rtcui_pkg::BITS_BYTE) begin
                     s_nxt.sda_drv = 1'b0;
                     s_nxt.ptr = s_r.ptr + 8'h01;
                     s_nxt.st = rtcui_pkg::ST_RACK;
                  end else begin
                     s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                     s_nxt.sda_drv = ~s_r.shreg[6];
                  end
               end
            end
            rtcui_pkg::ST_RACK: begin
               if (scl_rise) begin
                  s_nxt.mnack = sy.sda;
               end else if (scl_fall) begin
                  if (s_r.mnack) begin
                     s_nxt.st = rtcui_pkg::ST_IDLE;
                  end else begin
                     s_nxt.shreg = rd_byte(s_r.ptr, s_r);
                     s_nxt.sda_drv = ~s_nxt.shreg[7];
                     s_nxt.bit_cnt = 4'h0;
                     s_nxt.st = rtcui_pkg::ST_RD;
                  end
               end
            end
            default: begin
               s_nxt.st = rtcui_pkg::ST_IDLE;
               s_nxt.sda_drv = 1'b0;
            end
         endcase
      end
      // Plain register writes
      if (wr_en) begin
         case (s_r.ptr)
            rtcui_pkg::REG_EXT: begin
               s_nxt.ext = s_r.shreg;
            end
            rtcui_pkg::REG_CTRL: begin
               s_nxt.ctl = s_r.shreg;
            end
            rtcui_pkg::REG_ROUTE: begin
               s_nxt.route = s_r.shreg[rtcui_pkg::ROUTE_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Sticky flags: only a written zero clears, a new event wins the clash
      upd_clr = wr_en && s_r.ptr == rtcui_pkg::REG_FLAGS && !s_r.shreg[rtcui_pkg::FLG_UPDATE_BIT];
      loss_clr = wr_en && s_r.ptr == rtcui_pkg::REG_FLAGS && !s_r.shreg[rtcui_pkg::FLG_LOSS_BIT];
      s_nxt.update_event_flag = (s_r.update_event_flag & ~upd_clr) | upd_evt;
      s_nxt.data_loss_flag = (s_r.data_loss_flag & ~loss_clr) | sy.loss;
      // Pin A hold window, restarted by every event
      if (upd_evt) begin
         s_nxt.irq_act = 1'b1;
         s_nxt.hold = HOLD_LD;
      end else if (upd_clr) begin
         s_nxt.irq_act = 1'b0;
         s_nxt.hold = '0;
      end else if (s_r.hold != '0) begin
         s_nxt.hold = s_r.hold - 18'h00001;
         if (s_r.hold == 18'h00001) begin
            s_nxt.irq_act = 1'b0;
         end
      end
      // Clock level; slow rates need the divider, which halt stops
      case (freq_sel)
         rtcui_pkg::FREQ_1HZ: begin
            ck_lvl = halt | sy.tick.hz1;
         end
         rtcui_pkg::FREQ_1K: begin
            ck_lvl = halt | sy.tick.hz1k;
         end
         rtcui_pkg::FREQ_32K: begin
            ck_lvl = sy.osc;
         end
         default: begin
            ck_lvl = 1'b1;
         end
      endcase
      // Outputs registered one cycle behind state; pin B idles off in backup
      s_nxt.pin_lo = 1'b0;
      s_nxt.sda_oe_n = ~s_r.sda_drv;
      s_nxt.irqa_oe_n = ~((s_r.irq_act & s_r.ctl[rtcui_pkg::CTL_UPD_IE_BIT])
                          | (pin_sel == rtcui_pkg::PIN_A && !ck_lvl));
      s_nxt.irqb_oe_n = ~(pin_sel == rtcui_pkg::PIN_B && !sy.backup && !ck_lvl);
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
         s_r.st <= rtcui_pkg::ST_IDLE;
         s_r.scl_q <= 1'b1;
         s_r.sda_q <= 1'b1;
         s_r.ext <= rtcui_pkg::EXT_RST;
         s_r.ctl <= rtcui_pkg::CTL_RST;
         s_r.route <= rtcui_pkg::ROUTE_RST;
         s_r.data_loss_flag <= rtcui_pkg::LOSS_RST;
         s_r.sda_oe_n <= 1'b1;
         s_r.irqa_oe_n <= 1'b1;
         s_r.irqb_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sda_o = s_r.pin_lo;
   assign sda_oe_n_o = s_r.sda_oe_n;
   assign interrupt_out_a_o = s_r.pin_lo;
   assign interrupt_out_a_oe_n_o = s_r.irqa_oe_n;
   assign interrupt_out_b_o = s_r.pin_lo;
   assign interrupt_out_b_oe_n_o = s_r.irqb_oe_n;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking sys_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence flag_zero_write;
      wr_en && s_r.ptr == rtcui_pkg::REG_FLAGS && !s_r.shreg[rtcui_pkg::FLG_UPDATE_BIT];
   endsequence
   sequence flag_one_write;
      wr_en && s_r.ptr == rtcui_pkg::REG_FLAGS && s_r.shreg[rtcui_pkg::FLG_UPDATE_BIT];
   endsequence

   chk_upd_flag_set: assert property (upd_evt |=> s_r.update_event_flag && s_r.irq_act && s_r.hold == HOLD_LD)
      else $error("update event did not set flag and hold");
   chk_upd_flag_one: assert property ((flag_one_write and !s_r.update_event_flag && !upd_evt)
                                      |=> !s_r.update_event_flag)
      else $error("writing one set the update flag");
   chk_hold_release: assert property ((s_r.irq_act && s_r.hold == 18'h00001 && !upd_evt) |=> !s_r.irq_act)
      else $error("pin A hold did not end on time");
   chk_flag_clear_pin: assert property ((flag_zero_write and !upd_evt && pin_sel != rtcui_pkg::PIN_A)
                                        |=> !s_r.irq_act ##1 interrupt_out_a_oe_n_o)
      else $error("flag clear did not release pin A");
   chk_enable_gate: assert property ((!s_r.ctl[rtcui_pkg::CTL_UPD_IE_BIT] && pin_sel != rtcui_pkg::PIN_A)
                                     |=> interrupt_out_a_oe_n_o)
      else $error("pin A driven with interrupt disabled");
   chk_loss_sticky: assert property ((s_r.data_loss_flag && !loss_clr) |=> s_r.data_loss_flag)
      else $error("data-loss flag dropped without a clear");
   chk_halt_slow_off: assert property ((halt && freq_sel != rtcui_pkg::FREQ_32K && pin_sel == rtcui_pkg::PIN_B)
                                       |=> interrupt_out_b_oe_n_o)
      else $error("slow clock reached pin B while halted");
   chk_freq_off_b: assert property ((freq_sel == rtcui_pkg::FREQ_OFF) |=> interrupt_out_b_oe_n_o)
      else $error("pin B driven with clock output off");
   chk_halt_no_evt: assert property (halt |-> !upd_evt ##1 $stable(s_r.irq_act) || !s_r.irq_act)
      else $error("update event while halted");
endmodule

// File: rtcui_host.sv
// Serial bus host model that reaches the register port
`timescale 1ns/1ps
module rtcui_host #(
   parameter logic [6:0] DEV = 7'h32
) (
   // Clock and resolved data wire
   input wire logic clk_i,
   input wire logic sda_i,
   // Open-drain drives, low pulls the wire
   output logic scl_o,
   output logic sda_oe_n_o
);
   logic ack_r;
   // Idle bus, both lines left to the pull-up
   initial begin
      scl_o = 1'b1;
      sda_oe_n_o = 1'b1;
      ack_r = 1'b0;
   end
   // Quarter bit of 4 cycles keeps both phases above the slave minimum
   task automatic qb();
      repeat (4) @(negedge clk_i);
   endtask
   task automatic bit_x(input logic b, output logic s);
      sda_oe_n_o = b;
      qb();
      scl_o = 1'b1;
      qb();
      s = sda_i;
      qb();
      scl_o = 1'b0;
      qb();
   endtask
   // Data falls only while the clock stands high, so the slave sees a clean start or repeated start
   task automatic start();
      sda_oe_n_o = 1'b1;
      qb();
      scl_o = 1'b1;
      qb();
      sda_oe_n_o = 1'b0;
      qb();
      scl_o = 1'b0;
      qb();
   endtask
   task automatic stop();
      sda_oe_n_o = 1'b0;
      qb();
      scl_o = 1'b1;
      qb();
      sda_oe_n_o = 1'b1;
      qb();
   endtask
   // One byte MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic mk, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i]);
      end
      bit_x(mk, k);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic k0, k1, k2;
      start();
      xfer({DEV, 1'b0}, 1'b1, r, k0);
      xfer(a, 1'b1, r, k1);
      xfer(d, 1'b1, r, k2);
      stop();
      ack_r = k0 | k1 | k2;
   endtask
   // Pointer write, repeated start, one byte read ended by a refusal
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic k0, k1, k2, k3;
      start();
      xfer({DEV, 1'b0}, 1'b1, r, k0);
      xfer(a, 1'b1, r, k1);
      start();
      xfer({DEV, 1'b1}, 1'b1, r, k2);
      xfer(8'hff, 1'b1, d, k3);
      stop();
      ack_r = k0 | k1 | k2;
   endtask
endmodule

// File: tb_rtc_update_irq_and_clock_out.sv
// Self-checking bench for update events, data-loss flag and clock output
`timescale 1ns/1ps
module tb_rtc_update_irq_and_clock_out;
   logic sys_clk_i = 1'b0;
   logic osc_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic data_loss_i = 1'b0;
   logic backup_i = 1'b0;
   logic scl, h_oe_n, sda_oe_n, a_oe_n, b_oe_n, ack;
   logic sda_d, a_d, b_d;
   logic [7:0] rd;
   wire sda = h_oe_n & sda_oe_n;
   int n_mismatch = 0;
   int n_checks = 0;
   int fa = 0;
   int fb = 0;
   int cyc = 0;
   int na, nb;
   // Rows: offset, write data, read back
   logic [23:0] rrow [9] = '{24'h1e0000, 24'h1eff00, 24'h1d3f3f, 24'h1f1c1c, 24'h32fe06,
      24'h40a500, 24'h1d0000, 24'h1f0000, 24'h320000};
   // Rows: ext, route, ctrl, backup, pin A falls lo/hi, pin B falls lo/hi
   logic [63:0] crow [8] = '{64'h80004000_00000000, 64'hc0014000_01ff0000, 64'hc0000000_000001ff,
      64'hc0000001_00000000, 64'h80010000_0b0d0000, 64'h40000000_00000001, 64'h80020000_00000000,
      64'h00000000_00000000};
   logic [15:0] rst_row [4] = '{16'h1d00, 16'h1e02, 16'h1f00, 16'h3200};
   // System clock and unrelated oscillator
   always #25 sys_clk_i = ~sys_clk_i;
   always #32 osc_clk_i = ~osc_clk_i;
   // Pin pull counters
   always @(negedge a_oe_n) fa++;
   always @(negedge b_oe_n) fb++;
   // Hang guard, a second costs about 42000 cycles
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 95000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   rtcui_top #(.IRQ_HOLD_CYC(20)) u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .osc_clk_i(osc_clk_i),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .interrupt_out_a_o(a_d),
      .interrupt_out_a_oe_n_o(a_oe_n), .interrupt_out_b_o(b_d), .interrupt_out_b_oe_n_o(b_oe_n),
      .data_loss_i(data_loss_i), .backup_i(backup_i));
   rtcui_host #(.DEV(rtcui_pkg::DEV_ADDR_DEF)) u_host (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl),
      .sda_oe_n_o(h_oe_n));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd_reg(a, rd);
      chk("reg_read", {8'h00, rd}, {8'h00, e});
   endtask
   // ************************************************************
   // Stimulus
   // ************************************************************
   initial begin
      repeat (12) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      foreach (rrow[i]) begin
         u_host.wr_reg(rrow[i][23:16], rrow[i][15:8]);
         rd_chk(rrow[i][23:16], rrow[i][7:0]);
         chk("reg_ack", {15'h0, u_host.ack_r}, 16'h0000);
      end
      // Mid-run reset, defaults come back
      rstn_i = 1'b0;
      repeat (12) @(negedge sys_clk_i);
      chk("pins_in_reset", {13'h0, a_oe_n, b_oe_n, sda_oe_n}, 16'h0007);
      chk("pin_data", {13'h0, a_d, b_d, sda_d}, 16'h0000);
      rstn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      foreach (rst_row[i]) rd_chk(rst_row[i][15:8], rst_row[i][7:0]);
      // Clear the power-on loss flag, then it must stay after the input drops
      u_host.wr_reg(rtcui_pkg::REG_FLAGS, 8'h00);
      rd_chk(rtcui_pkg::REG_FLAGS, 8'h00);
      data_loss_i = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      data_loss_i = 1'b0;
      rd_chk(rtcui_pkg::REG_FLAGS, 8'h02);
      u_host.wr_reg(rtcui_pkg::REG_FLAGS, 8'h00);
      rd_chk(rtcui_pkg::REG_FLAGS, 8'h00);
      u_host.start();
      u_host.xfer({~rtcui_pkg::DEV_ADDR_DEF, 1'b0}, 1'b1, rd, ack);
      u_host.stop();
      chk("foreign_addr_ack", {15'h0, ack}, 16'h0001);
      foreach (crow[i]) begin
         u_host.wr_reg(rtcui_pkg::REG_CTRL, crow[i][47:40]);
         u_host.wr_reg(rtcui_pkg::REG_EXT, crow[i][63:56]);
         u_host.wr_reg(rtcui_pkg::REG_ROUTE, crow[i][55:48]);
         backup_i = crow[i][32];
         repeat (8) @(negedge sys_clk_i);
         na = fa;
         nb = fb;
         repeat (500) @(negedge sys_clk_i);
         chk("pin_a_falls", 16'(fa - na >= crow[i][31:24] && fa - na <= crow[i][23:16]), 16'h1);
         chk("pin_b_falls", 16'(fb - nb >= crow[i][15:8] && fb - nb <= crow[i][7:0]), 16'h1);
         // Halted divider sits at zero, so a leaking slow clock would hold pin B low
         if (i == 0) begin
            chk("halt_pin_b", {15'h0, b_oe_n}, 16'h0001);
         end
      end
      chk("pins_idle", {14'h0, a_oe_n, b_oe_n}, 16'h0003);
      // Wait for the next second rollover with the pin enabled
      u_host.wr_reg(rtcui_pkg::REG_CTRL, 8'h20);
      na = 0;
      while (a_oe_n !== 1'b0 && na < 60000) begin
         @(negedge sys_clk_i);
         na++;
      end
      nb = 0;
      while (a_oe_n === 1'b0 && nb < 100) begin
         @(negedge sys_clk_i);
         nb++;
      end
      chk("irq_low_cycles", 16'(nb), 16'h0014);
      rd_chk(rtcui_pkg::REG_FLAGS, 8'h20);
      u_host.wr_reg(rtcui_pkg::REG_FLAGS, 8'h00);
      rd_chk(rtcui_pkg::REG_FLAGS, 8'h00);
      report_and_stop();
   end
endmodule
